/* hw/serial_cfg_pkg.sv */
// Function
// - High write buffered; low write loads divisor
// - Generator idle until rx_on or tx_on set
// - Zero divisor stops the baud generator
// - Break flag with enable requests interrupt
// - Receive edge flag with enable requests interrupt
// - Internal return feeds transmitter into receiver
// - Single-wire select valid only with internal return
// - Freeze_in_wait stops serial clocks in wait
// - Nine_bit_select adds ninth data bit
// - Address_mark_select picks the wakeup method
// - Idle count starts after start or stop
// - Parity_enable generates and checks parity on MSB
// - Parity_odd_select picks even or odd parity
package serial_cfg_pkg;
    // Register byte addresses on the APB slave
    localparam logic [7:0] BAUD_HIGH_OFFSET = 8'h00;
    localparam logic [7:0] BAUD_LOW_OFFSET = 8'h04;
    localparam logic [7:0] CONTROL_ONE_OFFSET = 8'h08;
    localparam logic [7:0] ENABLES_OFFSET = 8'h0C;

    // Field positions
    localparam int BREAK_IRQ_EN_BIT = 7;
    localparam int EDGE_IRQ_EN_BIT = 6;
    localparam int DIV_HIGH_MSB = 4;
    localparam int TX_ON_BIT = 3;
    localparam int RX_ON_BIT = 2;
    localparam int DIVISOR_WIDTH = 13;

    // Reset values; baud_low is non-zero out of reset
    localparam logic [7:0] BAUD_HIGH_RESET = 8'h00;
    localparam logic [7:0] BAUD_LOW_RESET = 8'h04;
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [7:0] BAUD_HIGH_MASK = 8'hDF;
    localparam logic [7:0] ENABLES_MASK = 8'h0C;

    // Oversampling and idle counts
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] IDLE_BITS_EIGHT = 4'hA;
    localparam logic [3:0] IDLE_BITS_NINE = 4'hB;

    // Control register one, bit 7 down to bit 0
    typedef struct packed {
        logic internalReturn;
        logic freezeInWait;
        logic singleWire;
        logic nineBit;
        logic addressMark;
        logic idleAfterStop;
        logic parityEnable;
        logic parityOdd;
    } control_one_t;

    // Baud generator status seen by the engines
    typedef struct packed {
        logic tick16;
        logic bitTick;
        logic running;
    } baud_out_t;
endpackage

/* hw/serial_baud_and_frame_config.sv */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module serial_baud_and_frame_config
    import serial_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Engine side
    input wire logic cpuWait,
    input wire logic txData,
    input wire logic txDirOut,
    input wire logic [8:0] txChar,
    input wire logic [8:0] rxChar,
    input wire logic rxCharValid,
    input wire logic rxStopDone,
    input wire logic breakDetectFlag,
    input wire logic rxEdgeFlag,
    output baud_out_t baudOut,
    output control_one_t frameCfg,
    output logic txParityBit,
    output logic parityError,
    output logic rxToReceiver,
    output logic idleDetected,
    output logic wakeupEvent,
    output logic irqRequest,
    // Pins
    input wire logic rxPin,
    input wire logic txPinIn,
    output logic txPinOut,
    output logic txPinOe_b
);
    logic [7:0] baudHigh_reg, baudHigh_next;
    logic [7:0] baudLow_reg, baudLow_next;
    logic [7:0] enables_reg, enables_next;
    logic [DIVISOR_WIDTH-1:0] divisor_reg, divisor_next;
    control_one_t controlOne_reg, controlOne_next;
    logic started_reg, started_next;
    logic [31:0] prdata_reg, prdata_next;
    logic setupPhase, accessPhase, wrAccess, mapped;
    logic [DIVISOR_WIDTH-1:0] count_reg, count_next;
    logic [3:0] subCount_reg, subCount_next;
    logic tick16_reg, tick16_next, bitTick_reg, bitTick_next, running;
    logic [1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;
    logic rxIn_reg, rxIn_next, txPinOut_reg, txPinOut_next, oe_b_reg, oe_b_next;
    logic [3:0] idleCount_reg, idleCount_next, idleNeeded;
    logic idleArmed_reg, idleArmed_next, idleDone_reg, idleDone_next;
    logic parErr_reg, parErr_next, txPar_reg, txPar_next;
    logic wake_reg, wake_next, irq_reg, irq_next;
    logic [8:0] rxMasked, txMasked;

    // Bus phases; every access completes in one access cycle
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrAccess = accessPhase && pwrite && mapped;
    assign mapped = (paddr == BAUD_HIGH_OFFSET) || (paddr == BAUD_LOW_OFFSET) ||
                    (paddr == CONTROL_ONE_OFFSET) || (paddr == ENABLES_OFFSET);
    assign pready = 1'b1;
    assign pslverr = accessPhase && !mapped;
    assign prdata = prdata_reg;
    // Register writes in the access cycle; read data captured in the setup cycle
    always_comb begin
        baudHigh_next = baudHigh_reg;
        baudLow_next = baudLow_reg;
        controlOne_next = controlOne_reg;
        enables_next = enables_reg;
        divisor_next = divisor_reg;
        started_next = started_reg;
        prdata_next = prdata_reg;
        if (wrAccess) begin
            case (paddr)
                // Only the buffer moves; working divisor waits for the low half
                BAUD_HIGH_OFFSET: baudHigh_next = pwdata[7:0] & BAUD_HIGH_MASK;
                BAUD_LOW_OFFSET: begin
                    baudLow_next = pwdata[7:0];
                    divisor_next = {baudHigh_reg[DIV_HIGH_MSB:0], pwdata[7:0]};
                end
                CONTROL_ONE_OFFSET: controlOne_next = control_one_t'(pwdata[7:0]);
                ENABLES_OFFSET: begin
                    enables_next = pwdata[7:0] & ENABLES_MASK;
                    // Latched once; turning both off later keeps the generator armed
                    if (pwdata[RX_ON_BIT] || pwdata[TX_ON_BIT]) begin
                        started_next = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (setupPhase) begin
            case (paddr)
                BAUD_HIGH_OFFSET: prdata_next = {24'h000000, baudHigh_reg};
                BAUD_LOW_OFFSET: prdata_next = {24'h000000, baudLow_reg};
                CONTROL_ONE_OFFSET: prdata_next = {24'h000000, controlOne_reg};
                ENABLES_OFFSET: prdata_next = {24'h000000, enables_reg};
                default: prdata_next = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            baudHigh_reg <= BAUD_HIGH_RESET;
            baudLow_reg <= BAUD_LOW_RESET;
            controlOne_reg <= control_one_t'(CONTROL_ONE_RESET);
            enables_reg <= ENABLES_RESET;
            divisor_reg <= {BAUD_HIGH_RESET[DIV_HIGH_MSB:0], BAUD_LOW_RESET};
            started_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            baudHigh_reg <= baudHigh_next;
            baudLow_reg <= baudLow_next;
            controlOne_reg <= controlOne_next;
            enables_reg <= enables_next;
            divisor_reg <= divisor_next;
            started_reg <= started_next;
            prdata_reg <= prdata_next;
        end
    end

    // Modulo divider: one tick every divisor clocks, so baud = clock / (16 x divisor)
    assign running = started_reg && (divisor_reg != '0) &&
                     !(cpuWait && controlOne_reg.freezeInWait);
    always_comb begin
        count_next = count_reg;
        subCount_next = subCount_reg;
        tick16_next = 1'b0;
        bitTick_next = 1'b0;
        if (!running || wrAccess && paddr == BAUD_LOW_OFFSET) begin
            // Held at rest so a stopped divider draws no switching power
            count_next = '0;
            if (!running) begin
                subCount_next = 4'h0;
            end
        end else if (count_reg >= divisor_reg - 13'h0001) begin
            count_next = '0;
            tick16_next = 1'b1;
            subCount_next = subCount_reg + 4'h1;
            bitTick_next = (subCount_reg == OVERSAMPLE_LAST);
        end else begin
            count_next = count_reg + 13'h0001;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
            subCount_reg <= 4'h0;
            tick16_reg <= 1'b0;
            bitTick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            subCount_reg <= subCount_next;
            tick16_reg <= tick16_next;
            bitTick_reg <= bitTick_next;
        end
    end
    assign baudOut = '{tick16: tick16_reg, bitTick: bitTick_reg, running: running};

    // Pin synchronisers: three stages, a change counts when stages two and three agree
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 2'h3;
            sync2_reg <= 2'h3;
            sync3_reg <= 2'h3;
        end else begin
            sync1_reg <= {txPinIn, rxPin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Line routing and pin drive
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            filt_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
        end
        if (!controlOne_reg.internalReturn) begin
            rxIn_next = filt_reg[0];
        end else if (!controlOne_reg.singleWire) begin
            rxIn_next = txData;
        end else begin
            rxIn_next = txDirOut ? txData : filt_reg[1];
        end
        txPinOut_next = txData;
        // In single-wire mode the pin is released while listening
        oe_b_next = !(enables_reg[TX_ON_BIT] &&
                      !(controlOne_reg.internalReturn && controlOne_reg.singleWire &&
                        !txDirOut));
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            filt_reg <= 2'h3;
            rxIn_reg <= 1'b1;
            txPinOut_reg <= 1'b1;
            oe_b_reg <= 1'b1;
        end else begin
            filt_reg <= filt_next;
            rxIn_reg <= rxIn_next;
            txPinOut_reg <= txPinOut_next;
            oe_b_reg <= oe_b_next;
        end
    end
    assign rxToReceiver = rxIn_reg;
    assign txPinOut = txPinOut_reg;
    assign txPinOe_b = oe_b_reg;

    // Idle line, wakeup, parity and interrupt request
    assign idleNeeded = controlOne_reg.nineBit ? IDLE_BITS_NINE : IDLE_BITS_EIGHT;
    assign rxMasked = controlOne_reg.nineBit ? rxChar : {1'b0, rxChar[7:0]};
    assign txMasked = controlOne_reg.nineBit ? {1'b0, txChar[7:0]} : {2'b00, txChar[6:0]};
    always_comb begin
        idleCount_next = idleCount_reg;
        idleArmed_next = idleArmed_reg;
        idleDone_next = 1'b0;
        if (!rxIn_reg) begin
            idleCount_next = 4'h0;
            // After-stop mode waits for the stop bit, so trailing ones are ignored
            idleArmed_next = !controlOne_reg.idleAfterStop;
        end else if (rxStopDone) begin
            idleArmed_next = 1'b1;
            if (controlOne_reg.idleAfterStop) begin
                idleCount_next = 4'h0;
            end
        end else if (bitTick_reg && idleArmed_reg && idleCount_reg != idleNeeded) begin
            idleCount_next = idleCount_reg + 4'h1;
            idleDone_next = (idleCount_reg + 4'h1 == idleNeeded);
        end
        // Most significant data bit is the address mark
        wake_next = controlOne_reg.addressMark ?
                    (rxCharValid && (controlOne_reg.nineBit ? rxChar[8] : rxChar[7])) :
                    idleDone_next;
        // Even parity makes the whole character hold an even count of ones
        txPar_next = controlOne_reg.parityEnable &&
                     ((^txMasked) ^ controlOne_reg.parityOdd);
        parErr_next = parErr_reg;
        if (rxCharValid) begin
            parErr_next = controlOne_reg.parityEnable &&
                          ((^rxMasked) != controlOne_reg.parityOdd);
        end
        irq_next = (baudHigh_reg[BREAK_IRQ_EN_BIT] && breakDetectFlag) ||
                   (baudHigh_reg[EDGE_IRQ_EN_BIT] && rxEdgeFlag);
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            idleCount_reg <= 4'h0;
            idleArmed_reg <= 1'b0;
            idleDone_reg <= 1'b0;
            wake_reg <= 1'b0;
            txPar_reg <= 1'b0;
            parErr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            idleCount_reg <= idleCount_next;
            idleArmed_reg <= idleArmed_next;
            idleDone_reg <= idleDone_next;
            wake_reg <= wake_next;
            txPar_reg <= txPar_next;
            parErr_reg <= parErr_next;
            irq_reg <= irq_next;
        end
    end
    assign frameCfg = controlOne_reg;
    assign idleDetected = idleDone_reg;
    assign wakeupEvent = wake_reg;
    assign txParityBit = txPar_reg;
    assign parityError = parErr_reg;
    assign irqRequest = irq_reg;

    // Helper: cycles since the previous tick while the divider runs steadily
    logic [DIVISOR_WIDTH:0] gap_reg;
    logic gapValid_reg;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gap_reg <= '0;
            gapValid_reg <= 1'b0;
        end else if (!running || wrAccess && paddr == BAUD_LOW_OFFSET) begin
            gap_reg <= '0;
            gapValid_reg <= 1'b0;
        end else if (tick16_next) begin
            gap_reg <= '0;
            gapValid_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 14'h0001;
        end
    end

    divisor_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        wrAccess && paddr == BAUD_HIGH_OFFSET |=> $stable(divisor_reg))
        else $error("divisor changed on high write");
    divisor_load_a: assert property (@(posedge clock) disable iff (!rst_b)
        wrAccess && paddr == BAUD_LOW_OFFSET |=>
        divisor_reg == {$past(baudHigh_reg[DIV_HIGH_MSB:0]), $past(pwdata[7:0])})
        else $error("divisor not loaded from both halves");
    gen_unstarted_a: assert property (@(posedge clock) disable iff (!rst_b)
        !started_reg ##1 !started_reg |-> !tick16_reg)
        else $error("tick before first enable");
    zero_divisor_a: assert property (@(posedge clock) disable iff (!rst_b)
        $past(divisor_reg) == '0 |-> !tick16_reg && count_reg == '0)
        else $error("generator active at zero divisor");
    tick_period_a: assert property (@(posedge clock) disable iff (!rst_b)
        tick16_next && gapValid_reg && running |-> gap_reg + 14'h0001 == {1'b0, divisor_reg})
        else $error("tick spacing differs from divisor");
    tick_single_a: assert property (@(posedge clock) disable iff (!rst_b)
        tick16_reg && $past(divisor_reg) > 13'h0001 |=> !tick16_reg)
        else $error("tick longer than one cycle");
    wait_freeze_a: assert property (@(posedge clock) disable iff (!rst_b)
        cpuWait && controlOne_reg.freezeInWait |-> !baudOut.running ##1 !baudOut.tick16)
        else $error("clock ran while frozen");
    break_irq_a: assert property (@(posedge clock) disable iff (!rst_b)
        breakDetectFlag && baudHigh_reg[BREAK_IRQ_EN_BIT] |=> irqRequest)
        else $error("break request missing");
    edge_irq_a: assert property (@(posedge clock) disable iff (!rst_b)
        !baudHigh_reg[EDGE_IRQ_EN_BIT] && !(breakDetectFlag && baudHigh_reg[BREAK_IRQ_EN_BIT])
        |=> !irqRequest)
        else $error("request without enable");
    loop_route_a: assert property (@(posedge clock) disable iff (!rst_b)
        controlOne_reg.internalReturn && !controlOne_reg.singleWire |=>
        rxToReceiver == $past(txData))
        else $error("loopback path broken");
    single_wire_a: assert property (@(posedge clock) disable iff (!rst_b)
        controlOne_reg.internalReturn && controlOne_reg.singleWire && !txDirOut |=>
        txPinOe_b && rxToReceiver == $past(filt_reg[1]))
        else $error("single-wire path broken");
    parity_gen_a: assert property (@(posedge clock) disable iff (!rst_b)
        controlOne_reg.parityEnable && !controlOne_reg.nineBit |=>
        txParityBit == ((^$past(txChar[6:0])) ^ $past(controlOne_reg.parityOdd)))
        else $error("parity bit wrong");

    tick_seen_c: cover property (@(posedge clock) disable iff (!rst_b)
        tick16_reg ##[1:20] tick16_reg);
    idle_seen_c: cover property (@(posedge clock) disable iff (!rst_b) idleDetected);
    parity_err_c: cover property (@(posedge clock) disable iff (!rst_b) parityError);
    irq_seen_c: cover property (@(posedge clock) disable iff (!rst_b) irqRequest);
endmodule // serial_baud_and_frame_config

/* test/remote_node.sv */
`timescale 1ns/1ps
// Far serial node; its line idles high like the pulled-up receive pin
module remote_node (
    // Clock and line
    input wire logic clock,
    output logic line
);
    initial line = 1'b1;

    // One character: start bit, data least significant first, stop, then idle high
    task automatic send(input logic [8:0] ch, input logic nine, input int bitClks);
        logic [10:0] fr;
        fr = nine ? {1'b1, ch, 1'b0} : {2'b11, ch[7:0], 1'b0};
        for (int i = 0; i < 11; i++) begin
            line <= fr[i];
            repeat (bitClks) @(posedge clock);
        end
    endtask
endmodule // remote_node

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import serial_cfg_pkg::*;
    logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, txParityBit, parityError, rxToReceiver, idleDetected;
    logic wakeupEvent, irqRequest, txPinOut, txPinOe_b, rxPin;
    logic cpuWait = 1'b0, txData = 1'b1, txDirOut = 1'b0, rxCharValid = 1'b0;
    logic rxStopDone = 1'b0, breakFlag = 1'b0, edgeFlag = 1'b0, extLine = 1'b0;
    logic [8:0] txChar = 9'h0, rxChar = 9'h0;
    baud_out_t baudOut;
    control_one_t frameCfg;
    wire txPinIn;
    int failures = 0, compares = 0, seed = 32'h4dadfba8, n;
    logic [33:0] expQ[$];
    logic [7:0] c;

    // Released single wire shows a level opposite to an idle pin
    assign txPinIn = txPinOe_b ? extLine : txPinOut;
    always #12.5 clock = ~clock;

    serial_baud_and_frame_config serial_baud_and_frame_config_i (.clock(clock), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuWait(cpuWait),
        .txData(txData), .txDirOut(txDirOut), .txChar(txChar), .rxChar(rxChar),
        .rxCharValid(rxCharValid), .rxStopDone(rxStopDone), .breakDetectFlag(breakFlag),
        .rxEdgeFlag(edgeFlag), .baudOut(baudOut), .frameCfg(frameCfg),
        .txParityBit(txParityBit), .parityError(parityError), .rxToReceiver(rxToReceiver),
        .idleDetected(idleDetected), .wakeupEvent(wakeupEvent), .irqRequest(irqRequest),
        .rxPin(rxPin), .txPinIn(txPinIn), .txPinOut(txPinOut), .txPinOe_b(txPinOe_b));
    remote_node remote_node_i (.clock(clock), .line(rxPin));

    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bitc(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    // Scoreboard: oldest note is matched at each completed access
    always @(posedge clock) begin : monitor
        logic [33:0] e;
        if (psel && penable && pready && expQ.size() > 0) begin
            e = expQ.pop_front();
            bitc(pslverr, e[32]);
            if (!e[33]) check(prdata, e[31:0]);
        end
    end

    // One APB transfer; d is write data or the expected read data
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        expQ.push_back({wr, err, d});
        @(posedge clock);
        penable <= 1'b1;
        // No cycle limit here; only the watchdog ends a stalled access
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function logic sel(int s);
        case (s)
            0: return baudOut.tick16;
            1: return baudOut.bitTick;
            2: return idleDetected;
            default: return wakeupEvent;
        endcase
    endfunction
    // Cycles until the chosen output pulses; lim means it never did
    task waitFor(input int s, input int lim, output int k);
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (sel(s) !== 1'b1 && k < lim);
    endtask
    task gap(input int s, output int k);
        waitFor(s, 5000, k);
        waitFor(s, 5000, k);
    endtask

    task tally_and_finish;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of some 2000 cycles
    initial begin
        #2000000;
        failures++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        apb(0, BAUD_HIGH_OFFSET, {24'h0, BAUD_HIGH_RESET}, 0);
        apb(0, BAUD_LOW_OFFSET, {24'h0, BAUD_LOW_RESET}, 0);
        apb(0, CONTROL_ONE_OFFSET, 32'h0, 0);
        apb(1, 8'h10, 32'hFF, 1);
        apb(0, 8'h10, 32'h0, 1);
        waitFor(0, 40, n);
        check(n, 40);
        $display("test reset and idle generator done");
        apb(1, ENABLES_OFFSET, 32'h04, 0);
        gap(0, n);
        check(n, 4);
        gap(1, n);
        check(n, 64);
        apb(1, BAUD_HIGH_OFFSET, 32'h01, 0);
        gap(0, n);
        check(n, 4);
        apb(1, BAUD_LOW_OFFSET, 32'h00, 0);
        gap(0, n);
        check(n, 256);
        apb(1, BAUD_HIGH_OFFSET, 32'hFF, 0);
        apb(0, BAUD_HIGH_OFFSET, 32'hDF, 0);
        apb(1, BAUD_HIGH_OFFSET, 32'h00, 0);
        apb(1, BAUD_LOW_OFFSET, 32'h03, 0);
        gap(0, n);
        check(n, 3);
        gap(1, n);
        check(n, 48);
        apb(1, ENABLES_OFFSET, 32'hFF, 0);
        apb(0, ENABLES_OFFSET, 32'h0C, 0);
        apb(1, BAUD_LOW_OFFSET, 32'h00, 0);
        @(negedge clock);
        bitc(baudOut.running, 1'b0);
        waitFor(0, 40, n);
        check(n, 40);
        apb(1, BAUD_LOW_OFFSET, 32'h01, 0);
        $display("test divisor done");
        // Wait mode with and without freezing
        apb(1, CONTROL_ONE_OFFSET, 32'h40, 0);
        cpuWait <= 1'b1;
        // A tick launched before the freeze still shows for one cycle
        @(posedge clock);
        waitFor(0, 20, n);
        check(n, 20);
        bitc(baudOut.running, 1'b0);
        apb(1, CONTROL_ONE_OFFSET, 32'h00, 0);
        waitFor(0, 20, n);
        bitc(n < 20, 1'b1);
        @(posedge clock);
        cpuWait <= 1'b0;
        $display("test wait mode done");
        // Interrupt enables against random flags
        for (int i = 0; i < 8; i++) begin
            apb(1, BAUD_HIGH_OFFSET, {24'h0, i[1:0], 6'h0}, 0);
            breakFlag <= $random(seed);
            edgeFlag <= $random(seed);
            repeat (3) @(negedge clock);
            bitc(irqRequest, (i[1] & breakFlag) | (i[0] & edgeFlag));
        end
        $display("test interrupt enables done");
        // Parity generation and checking for every mode
        for (int i = 0; i < 8; i++) begin
            apb(1, CONTROL_ONE_OFFSET, {27'h0, i[2], 2'b00, i[0], i[1]}, 0);
            txChar <= $random(seed);
            rxChar <= $random(seed);
            rxCharValid <= 1'b1;
            @(posedge clock);
            rxCharValid <= 1'b0;
            repeat (3) @(negedge clock);
            bitc(txParityBit, i[0] & ((i[2] ? ^txChar[7:0] : ^txChar[6:0]) ^ i[1]));
            bitc(parityError, i[0] & ((i[2] ? ^rxChar : ^rxChar[7:0]) ^ i[1]));
            bitc(frameCfg.nineBit, i[2]);
        end
        $display("test parity done");
        // Receiver routing: normal, internal return, single wire
        apb(1, CONTROL_ONE_OFFSET, 32'h00, 0);
        txData <= 1'b0;
        repeat (10) @(negedge clock);
        bitc(rxToReceiver, 1'b1);
        apb(1, CONTROL_ONE_OFFSET, 32'h80, 0);
        repeat (10) @(negedge clock);
        bitc(rxToReceiver, 1'b0);
        bitc(txPinOut, 1'b0);
        apb(1, CONTROL_ONE_OFFSET, 32'hA0, 0);
        txData <= 1'b1;
        txDirOut <= 1'b1;
        repeat (10) @(negedge clock);
        bitc(txPinOe_b, 1'b0);
        bitc(rxToReceiver, 1'b1);
        @(posedge clock);
        txDirOut <= 1'b0;
        repeat (10) @(negedge clock);
        bitc(txPinOe_b, 1'b1);
        bitc(rxToReceiver, 1'b0);
        $display("test routing done");
        // Address-mark wakeup on the most significant data bit
        apb(1, CONTROL_ONE_OFFSET, 32'h08, 0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            c = $random(seed);
            c[7] = i[0];
            rxChar <= {1'b0, c};
            rxCharValid <= 1'b1;
            @(posedge clock);
            rxCharValid <= 1'b0;
            waitFor(3, 4, n);
            bitc(n < 4, c[7]);
        end
        $display("test wakeup done");
        // Idle count armed after a stop bit, then after a start bit, bit time 16 clocks
        apb(1, CONTROL_ONE_OFFSET, 32'h04, 0);
        remote_node_i.send(9'h1FF, 1'b0, 16);
        waitFor(2, 224, n);
        check(n, 224);
        @(posedge clock);
        rxStopDone <= 1'b1;
        @(posedge clock);
        rxStopDone <= 1'b0;
        waitFor(2, 220, n);
        bitc(n >= 144 && n <= 200, 1'b1);
        apb(1, CONTROL_ONE_OFFSET, 32'h00, 0);
        remote_node_i.send(9'h055, 1'b0, 16);
        waitFor(2, 220, n);
        bitc(n < 200, 1'b1);
        bitc(wakeupEvent, 1'b1);
        $display("test idle detect done");
        tally_and_finish;
    end
endmodule // tb_top
